// file: src/vdrb_pkg.sv
// Purpose: Shared constants and carriers for the teletext and caption readback block.
// Assumes: A single system clock; the host port is already in this clock domain.
// Notes:   Offsets are host port byte addresses; configuration reset values live here only.
//
// How it works
// - Each teletext location read returns the next stored byte and pops it.
// - Reading an empty teletext FIFO repeats the previous byte, state unchanged.
// - Caption register gives first byte, then second byte on successive reads.
// - After both caption bytes, reads return the first byte until new data.
// - Caption arrival sets that field's caption-ready status bit.
// - Caption-ready clears only after both bytes of that field are read.
// - Threshold status sets once stored transactions reach the 4-bit threshold.
// - Threshold field resets to five.
// - A 5-bit line number selects where line-qualified status events occur.
// - Line number is examined at each line start; changes apply next line.
// - Line number zero suppresses all three line-qualified events.
// - Line number field resets to twenty-four.
// - With data-required high, teletext event needs stored data.
// - Data-required has no effect on caption events.
// - Data-required bit resets to one.
// - Threshold status reads one at or above threshold, zero otherwise.

package vdrb_pkg;

  // ****************************************************************
  // Register offsets
  // ****************************************************************
  localparam logic [7:0] ADDR_TTX     = 8'hb0;
  localparam logic [7:0] ADDR_CC_ODD  = 8'hb1;
  localparam logic [7:0] ADDR_CC_EVEN = 8'hb2;
  localparam logic [7:0] ADDR_BUF     = 8'hb3;
  localparam logic [7:0] ADDR_THR     = 8'hb4;
  localparam logic [7:0] ADDR_LINE    = 8'hb5;

  // ****************************************************************
  // Reset values and sizes
  // ****************************************************************
  localparam logic [3:0] THR_RST      = 4'h5;
  localparam logic [4:0] LINE_RST     = 5'h18;
  localparam logic       REQ_RST      = 1'b1;
  localparam int         FIFO_DEPTH   = 16;
  localparam logic [4:0] CNT_SAT      = 5'h0f;

  // ****************************************************************
  // Carriers
  // ****************************************************************
  // Host port request, one cycle per access
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } vdrb_req_s;

  // One sliced teletext byte with end-of-transaction mark
  typedef struct packed {
    logic       last;
    logic [7:0] data;
  } vdrb_ttx_s;

  // One caption message; field high means odd field
  typedef struct packed {
    logic        odd;
    logic [15:0] bytes;
  } vdrb_cc_s;

  // Buffer status register layout
  typedef struct packed {
    logic       odd_caption_ready;
    logic       even_caption_ready;
    logic [3:0] tx_count;
    logic       fifo_full;
    logic       ttx_avail;
  } vdrb_buf_s;

endpackage

// file: src/vdrb_fifo.sv
// Purpose: First-word-fall-through FIFO with valid/ready on both sides.
// Assumes: DEPTH is a power of two.
// Notes:   Output data is the head word, valid while not empty.
`timescale 1ns/1ns

module vdrb_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  input  wire logic             i_sys_clk,
  input  wire logic             i_reset,
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic [WIDTH-1:0]      o_out_data
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW:0]      cnt_reg;
  logic [AW:0]      cnt_next;
  logic             in_ready_reg;
  logic             empty_reg;
  logic             push;
  logic             pop;

  // Handshakes
  assign push        = i_in_valid && in_ready_reg;
  assign pop         = !empty_reg && i_out_ready;
  assign o_in_ready  = in_ready_reg;
  assign o_out_valid = !empty_reg;
  assign o_out_data  = mem[rd_ptr_reg];

  // Occupancy next value
  always_comb
  begin
    cnt_next = cnt_reg;
    case ({push, pop})
      2'b10:   cnt_next = cnt_reg + 1'b1;
      2'b01:   cnt_next = cnt_reg - 1'b1;
      default: cnt_next = cnt_reg;
    endcase
  end

  // Storage array, no reset needed
  always_ff @(posedge i_sys_clk)
  begin
    if (push)
    begin
      mem[wr_ptr_reg] <= i_in_data;
    end
  end

  // Pointers and flags
  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      cnt_reg    <= '0;
      in_ready_reg <= 1'b1;
      empty_reg  <= 1'b1;
    end
    else
    begin
      if (push)
      begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (pop)
      begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
      cnt_reg   <= cnt_next;
      in_ready_reg <= (cnt_next != (AW+1)'(DEPTH));
      empty_reg <= (cnt_next == '0);
    end
  end

endmodule

// file: src/vdrb_top.sv
// Purpose: Host readback of teletext FIFO, caption registers and status.
// Assumes: Slicer, line timing and host port all run on i_sys_clk.
// Notes:   Line-qualified events are one-cycle pulses for the status register.
`timescale 1ns/1ns

module vdrb_top (
  input  wire logic                i_sys_clk,
  input  wire logic                i_reset,
  input  wire vdrb_pkg::vdrb_req_s i_host_req,
  output logic [7:0]               o_host_rdata,
  output logic                     o_host_rvalid,
  input  wire logic                i_ttx_valid,
  input  wire vdrb_pkg::vdrb_ttx_s i_ttx_word,
  output logic                     o_ttx_ready,
  input  wire logic                i_cc_valid,
  input  wire vdrb_pkg::vdrb_cc_s  i_cc_word,
  input  wire logic                i_line_start,
  input  wire logic [9:0]          i_line_num,
  output logic                     o_ttx_data_evt,
  output logic                     o_cc_even_evt,
  output logic                     o_cc_odd_evt,
  output logic                     o_ttx_thresh
);

  import vdrb_pkg::*;

  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic        rd_ttx;
  logic [1:0]  rd_cc;
  logic        fifo_valid;
  vdrb_ttx_s   fifo_head;
  logic        fifo_pop;
  logic        push_last;
  logic        pop_last;
  logic [7:0]  last_ttx_reg;
  logic [4:0]  tx_cnt_reg;
  logic [3:0]  thr_reg;
  logic [4:0]  line_sel_reg;
  logic        data_req_reg;
  logic [15:0] cc_data_reg   [2];
  logic [1:0]  cc_second_reg;
  logic [1:0]  cc_ready_reg;
  logic        line_hit;
  vdrb_buf_s   buf_stat;

  // Caption byte for the current read phase
  function automatic logic [7:0] cc_byte(input logic [15:0] bytes, input logic second);
    cc_byte = second ? bytes[15:8] : bytes[7:0];
  endfunction

  // ****************************************************************
  // Host port decode
  // ****************************************************************
  // Read strobes per location; index 0 even, 1 odd
  assign rd_ttx   = i_host_req.rd && (i_host_req.addr == ADDR_TTX);
  assign rd_cc[0] = i_host_req.rd && (i_host_req.addr == ADDR_CC_EVEN);
  assign rd_cc[1] = i_host_req.rd && (i_host_req.addr == ADDR_CC_ODD);

  // ****************************************************************
  // Teletext FIFO
  // ****************************************************************
  // Pop only when a byte is present
  assign fifo_pop  = rd_ttx && fifo_valid;
  assign push_last = i_ttx_valid && o_ttx_ready && i_ttx_word.last;
  assign pop_last  = fifo_pop && fifo_head.last;

  vdrb_fifo #(
    .WIDTH ($bits(vdrb_ttx_s)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .i_sys_clk   (i_sys_clk),
    .i_reset     (i_reset),
    .i_in_valid  (i_ttx_valid),
    .o_in_ready  (o_ttx_ready),
    .i_in_data   (i_ttx_word),
    .o_out_valid (fifo_valid),
    .i_out_ready (rd_ttx),
    .o_out_data  (fifo_head)
  );

  // Byte returned again when the FIFO runs dry
  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset)
    begin
      last_ttx_reg <= 8'h00;
    end
    else if (fifo_pop)
    begin
      last_ttx_reg <= fifo_head.data;
    end
  end

  // Complete transactions held; marks come from the slicer
  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset)
    begin
      tx_cnt_reg <= 5'h00;
    end
    else if (push_last && !pop_last)
    begin
      tx_cnt_reg <= tx_cnt_reg + 1'b1;
    end
    else if (pop_last && !push_last)
    begin
      tx_cnt_reg <= tx_cnt_reg - 1'b1;
    end
  end

  AST_EMPTY_HOLD: assert property (
    @(posedge i_sys_clk) disable iff (i_reset)
    (rd_ttx && !fifo_valid) |=> (o_host_rdata == $past(last_ttx_reg))
                                && (tx_cnt_reg == $past(tx_cnt_reg) + {4'h0, $past(push_last)}))
    else $error("empty teletext read did not repeat last byte");

  AST_POP_DATA: assert property (
    @(posedge i_sys_clk) disable iff (i_reset)
    (rd_ttx && fifo_valid) |=> (o_host_rdata == $past(fifo_head.data))
                               && (last_ttx_reg == o_host_rdata))
    else $error("teletext read returned wrong byte");

  // ****************************************************************
  // Caption registers
  // ****************************************************************
  // New message wins over a read in the same cycle
  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset)
    begin
      cc_data_reg[0] <= 16'h0000;
      cc_data_reg[1] <= 16'h0000;
      cc_second_reg  <= 2'h0;
      cc_ready_reg   <= 2'h0;
    end
    else
    begin
      for (int f = 0; f < 2; f++)
      begin
        if (i_cc_valid && (i_cc_word.odd == f[0]))
        begin
          cc_data_reg[f]   <= i_cc_word.bytes;
          cc_ready_reg[f]  <= 1'b1;
          cc_second_reg[f] <= 1'b0;
        end
        else if (rd_cc[f] && cc_ready_reg[f] && cc_second_reg[f])
        begin
          cc_ready_reg[f]  <= 1'b0;
          cc_second_reg[f] <= 1'b0;
        end
        else if (rd_cc[f] && cc_ready_reg[f])
        begin
          cc_second_reg[f] <= 1'b1;
        end
      end
    end
  end

  AST_CC_SET: assert property (
    @(posedge i_sys_clk) disable iff (i_reset)
    i_cc_valid |=> cc_ready_reg[$past(i_cc_word.odd)] && !cc_second_reg[$past(i_cc_word.odd)])
    else $error("caption ready not set on arrival");

  AST_CC_CLEAR: assert property (
    @(posedge i_sys_clk) disable iff (i_reset)
    $fell(cc_ready_reg[0]) |-> $past(rd_cc[0] && cc_second_reg[0]))
    else $error("even caption ready cleared before both bytes read");

  AST_CC_ORDER: assert property (
    @(posedge i_sys_clk) disable iff (i_reset)
    (rd_cc[1] && !i_cc_valid && cc_ready_reg[1] && !cc_second_reg[1])
      ##1 (rd_cc[1] && !i_cc_valid) ##1 (rd_cc[1] && !i_cc_valid)
    |-> ##1 (o_host_rdata == cc_data_reg[1][7:0])
            && ($past(o_host_rdata) == cc_data_reg[1][15:8])
            && ($past(o_host_rdata, 2) == cc_data_reg[1][7:0]))
    else $error("odd caption bytes out of order");

  // ****************************************************************
  // Configuration registers
  // ****************************************************************
  // Host writes to threshold and line select
  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset)
    begin
      thr_reg      <= THR_RST;
      line_sel_reg <= LINE_RST;
      data_req_reg <= REQ_RST;
    end
    else if (i_host_req.wr && (i_host_req.addr == ADDR_THR))
    begin
      thr_reg <= i_host_req.wdata[3:0];
    end
    else if (i_host_req.wr && (i_host_req.addr == ADDR_LINE))
    begin
      data_req_reg <= i_host_req.wdata[5];
      line_sel_reg <= i_host_req.wdata[4:0];
    end
  end

  AST_RST_VALS: assert property (
    @(posedge i_sys_clk)
    i_reset |=> (thr_reg == THR_RST) && (line_sel_reg == LINE_RST)
                       && data_req_reg)
    else $error("configuration reset values wrong");

  // ****************************************************************
  // Line-qualified events
  // ****************************************************************
  // Selection examined only at line start; zero never matches
  assign line_hit = i_line_start && (line_sel_reg != 5'h00)
                    && (i_line_num == {5'h00, line_sel_reg});

  // One-cycle event pulses
  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset)
    begin
      o_ttx_data_evt <= 1'b0;
      o_cc_even_evt  <= 1'b0;
      o_cc_odd_evt   <= 1'b0;
    end
    else
    begin
      o_ttx_data_evt <= line_hit && (!data_req_reg || (tx_cnt_reg != 5'h00));
      o_cc_even_evt  <= line_hit && cc_ready_reg[0];
      o_cc_odd_evt   <= line_hit && cc_ready_reg[1];
    end
  end

  AST_LINE_ZERO: assert property (
    @(posedge i_sys_clk) disable iff (i_reset)
    (line_sel_reg == 5'h00) |=> !o_ttx_data_evt && !o_cc_even_evt && !o_cc_odd_evt)
    else $error("event raised with line select zero");

  AST_DATA_REQ: assert property (
    @(posedge i_sys_clk) disable iff (i_reset)
    o_ttx_data_evt |-> $past(i_line_start) && $past(i_line_num[4:0] == line_sel_reg)
                       && (!$past(data_req_reg) || ($past(tx_cnt_reg) != 5'h00)))
    else $error("teletext event without its conditions");

  AST_LINE_ONLY: assert property (
    @(posedge i_sys_clk) disable iff (i_reset)
    !i_line_start |=> !o_ttx_data_evt && !o_cc_even_evt && !o_cc_odd_evt)
    else $error("event raised outside line start");

  // ****************************************************************
  // Status and read data
  // ****************************************************************
  // Buffer status fields; count saturates at field width
  always_comb
  begin
    buf_stat.odd_caption_ready  = cc_ready_reg[1];
    buf_stat.even_caption_ready = cc_ready_reg[0];
    buf_stat.tx_count  = (tx_cnt_reg > CNT_SAT) ? CNT_SAT[3:0] : tx_cnt_reg[3:0];
    buf_stat.fifo_full = !o_ttx_ready;
    buf_stat.ttx_avail = (tx_cnt_reg != 5'h00);
  end

  // Threshold status level
  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset)
    begin
      o_ttx_thresh <= 1'b0;
    end
    else
    begin
      o_ttx_thresh <= (tx_cnt_reg >= {1'b0, thr_reg});
    end
  end

  AST_THRESH: assert property (
    @(posedge i_sys_clk) disable iff (i_reset)
    ##1 (o_ttx_thresh == ($past(tx_cnt_reg) >= {1'b0, $past(thr_reg)})))
    else $error("threshold status disagrees with count");

  // Registered read data, unmapped reads as zero
  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset)
    begin
      o_host_rdata  <= 8'h00;
      o_host_rvalid <= 1'b0;
    end
    else
    begin
      o_host_rvalid <= i_host_req.rd;
      if (i_host_req.rd)
      begin
        case (i_host_req.addr)
          ADDR_TTX:     o_host_rdata <= fifo_valid ? fifo_head.data : last_ttx_reg;
          ADDR_CC_EVEN: o_host_rdata <= cc_byte(cc_data_reg[0], cc_second_reg[0]);
          ADDR_CC_ODD:  o_host_rdata <= cc_byte(cc_data_reg[1], cc_second_reg[1]);
          ADDR_BUF:     o_host_rdata <= buf_stat;
          ADDR_THR:     o_host_rdata <= {4'h0, thr_reg};
          ADDR_LINE:    o_host_rdata <= {2'h0, data_req_reg, line_sel_reg};
          default:      o_host_rdata <= 8'h00;
        endcase
      end
    end
  end

  AST_AVAIL: assert property (
    @(posedge i_sys_clk) disable iff (i_reset)
    (i_host_req.rd && (i_host_req.addr == ADDR_BUF))
      |=> (o_host_rdata[0] == ($past(tx_cnt_reg) != 5'h00))
          && (o_host_rdata[1] == !$past(o_ttx_ready)))
    else $error("buffer status bits wrong");

endmodule

// file: bench/vdrb_host_model.sv
// Purpose: Host microcontroller model driving the register port.
// Assumes: Requests change 1 ns after a rising edge; wr and rd are one-cycle pulses, except rd3, which holds rd for three cycles.
// Notes:   The read port shows no transaction ends, so the host counts bytes itself.
`timescale 1ns/1ns

module vdrb_host_model (
  input  wire logic           i_sys_clk,
  input  wire logic [7:0]     i_host_rdata,
  input  wire logic           i_host_rvalid,
  output vdrb_pkg::vdrb_req_s o_host_req
);
  import vdrb_pkg::*;

  // Idle port from time zero
  initial o_host_req = '0;

  // One read; the answer is taken one edge after the request edge
  task automatic rd(input logic [7:0] addr, output logic [7:0] data, output logic ok);
    @(posedge i_sys_clk);
    #1;
    o_host_req.rd = 1'b1;
    o_host_req.addr = addr;
    @(posedge i_sys_clk);
    #1;
    o_host_req.rd = 1'b0;
    ok = i_host_rvalid;
    data = i_host_rdata;
  endtask

  // One write; no answer comes back
  task automatic wr(input logic [7:0] addr, input logic [7:0] data);
    @(posedge i_sys_clk);
    #1;
    o_host_req.wr = 1'b1;
    o_host_req.addr = addr;
    o_host_req.wdata = data;
    @(posedge i_sys_clk);
    #1;
    o_host_req.wr = 1'b0;
  endtask

  // Three back-to-back reads of one place, answers taken edge by edge
  task automatic rd3(input logic [7:0] addr, output logic [7:0] d [3]);
    @(posedge i_sys_clk);
    #1;
    o_host_req.rd = 1'b1;
    o_host_req.addr = addr;
    for (int i = 0; i < 3; i++)
    begin
      @(posedge i_sys_clk);
      #1;
      if (i == 2) o_host_req.rd = 1'b0;
      d[i] = i_host_rdata;
    end
  endtask

  // Pops one transaction whose length the host knows
  task automatic rd_txn(input int len, output logic [7:0] bytes [16]);
    logic ok;
    for (int i = 0; i < len; i++) rd(ADDR_TTX, bytes[i], ok);
  endtask
endmodule

// file: bench/tb_top.sv
// Purpose: Self-checking bench for the teletext and caption readback block.
// Assumes: Slicer and line timing stimulus is driven here 1 ns after each edge.
// Notes:   Expected values come from the register map and reset constants.
`timescale 1ns/1ns

module tb_top;
  import vdrb_pkg::*;

  logic       i_sys_clk = 1'b0;
  logic       i_reset = 1'b1;
  vdrb_req_s  host_req;
  logic [7:0] host_rdata;
  logic       host_rvalid;
  logic       ttx_valid = 1'b0;
  vdrb_ttx_s  ttx_word = '0;
  logic       ttx_ready;
  logic       cc_valid = 1'b0;
  vdrb_cc_s   cc_word = '0;
  logic       line_start = 1'b0;
  logic [9:0] line_num = 10'h000;
  logic       ttx_evt;
  logic       even_evt;
  logic       odd_evt;
  logic       thresh;
  int         err_total = 0;
  int         checked = 0;

  // ****************************************************************
  // Clock, design and host
  // ****************************************************************
  always #10 i_sys_clk = ~i_sys_clk;

  vdrb_top vdrb_top_inst (
    .i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_host_req(host_req),
    .o_host_rdata(host_rdata), .o_host_rvalid(host_rvalid),
    .i_ttx_valid(ttx_valid), .i_ttx_word(ttx_word), .o_ttx_ready(ttx_ready),
    .i_cc_valid(cc_valid), .i_cc_word(cc_word), .i_line_start(line_start),
    .i_line_num(line_num), .o_ttx_data_evt(ttx_evt), .o_cc_even_evt(even_evt),
    .o_cc_odd_evt(odd_evt), .o_ttx_thresh(thresh)
  );

  vdrb_host_model vdrb_host_model_inst (
    .i_sys_clk(i_sys_clk), .i_host_rdata(host_rdata),
    .i_host_rvalid(host_rvalid), .o_host_req(host_req)
  );

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  // Compare and count
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Register read with answer check
  task automatic rdchk(input string name, input logic [7:0] addr, input logic [7:0] exp);
    logic [7:0] d;
    logic       ok;
    vdrb_host_model_inst.rd(addr, d, ok);
    chk("rvalid", 8'h01, {7'h00, ok});
    chk(name, exp, d);
  endtask

  // Offer one slicer byte and hold it until taken
  task automatic push(input logic [7:0] data, input logic last);
    logic ok;
    @(posedge i_sys_clk);
    #1;
    ttx_valid = 1'b1;
    ttx_word = '{last: last, data: data};
    do
    begin
      ok = ttx_ready;
      @(posedge i_sys_clk);
    end while (ok !== 1'b1);
    #1;
    ttx_valid = 1'b0;
  endtask

  // Deliver one caption message
  task automatic cc(input logic odd, input logic [15:0] bytes);
    @(posedge i_sys_clk);
    #1;
    cc_valid = 1'b1;
    cc_word = '{odd: odd, bytes: bytes};
    @(posedge i_sys_clk);
    #1;
    cc_valid = 1'b0;
  endtask

  // Line start pulse, then the three event pulses
  task automatic line(input logic [9:0] n, input logic [2:0] exp);
    @(posedge i_sys_clk);
    #1;
    line_start = 1'b1;
    line_num = n;
    @(posedge i_sys_clk);
    #1;
    line_start = 1'b0;
    chk("events", {5'h00, exp}, {5'h00, ttx_evt, even_evt, odd_evt});
  endtask

  // Threshold level two edges after the last change
  task automatic thr(input logic exp);
    repeat (2) @(posedge i_sys_clk);
    #1;
    chk("thresh", {7'h00, exp}, {7'h00, thresh});
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  // Reset values, read-only and unmapped places
  task automatic t_reset;
    rdchk("thr", ADDR_THR, 8'h05);
    rdchk("line", ADDR_LINE, 8'h38);
    vdrb_host_model_inst.wr(ADDR_BUF, 8'hff);
    rdchk("buf", ADDR_BUF, 8'h00);
    rdchk("unmapped", 8'hc0, 8'h00);
  endtask

  // Two three-byte transactions, then an empty read
  task automatic t_ttx;
    logic [7:0] b [16];
    for (int i = 0; i < 6; i++) push(8'ha0 + i[7:0], (i % 3) == 2);
    rdchk("buf", ADDR_BUF, 8'h09);
    thr(1'b0);
    for (int t = 0; t < 2; t++)
    begin
      vdrb_host_model_inst.rd_txn(3, b);
      for (int i = 0; i < 3; i++) chk("ttx", 8'ha0 + 8'(3 * t + i), b[i]);
    end
    rdchk("ttx_empty", ADDR_TTX, 8'ha5);
    rdchk("buf", ADDR_BUF, 8'h00);
  endtask

  // Fill to refusal with threshold 2, then drain
  task automatic t_fill;
    vdrb_host_model_inst.wr(ADDR_THR, 8'h02);
    rdchk("thr", ADDR_THR, 8'h02);
    push(8'h40, 1'b1);
    thr(1'b0);
    for (int i = 1; i < FIFO_DEPTH; i++) push(8'h40 + i[7:0], 1'b1);
    thr(1'b1);
    chk("ready", 8'h00, {7'h00, ttx_ready});
    rdchk("buf", ADDR_BUF, 8'h3f);
    for (int i = 0; i < FIFO_DEPTH; i++) rdchk("drain", ADDR_TTX, 8'h40 + i[7:0]);
    rdchk("buf", ADDR_BUF, 8'h00);
    thr(1'b0);
  endtask

  // Caption pairs for both fields
  task automatic t_cc;
    logic [7:0] a;
    logic [7:0] m;
    logic [7:0] d [3];
    for (int f = 0; f < 2; f++)
    begin
      a = f ? ADDR_CC_ODD : ADDR_CC_EVEN;
      m = f ? 8'h80 : 8'h40;
      cc(f[0], {8'h3c + f[7:0], 8'hc3 - f[7:0]});
      rdchk("ready", ADDR_BUF, m);
      rdchk("cc1", a, 8'hc3 - f[7:0]);
      rdchk("ready", ADDR_BUF, m);
      rdchk("cc2", a, 8'h3c + f[7:0]);
      rdchk("ready", ADDR_BUF, 8'h00);
      rdchk("cc3", a, 8'hc3 - f[7:0]);
    end
    cc(1'b1, 16'h5aa5);
    vdrb_host_model_inst.rd3(ADDR_CC_ODD, d);
    chk("burst1", 8'ha5, d[0]);
    chk("burst2", 8'h5a, d[1]);
    chk("burst3", 8'ha5, d[2]);
    rdchk("ready", ADDR_BUF, 8'h00);
  endtask

  // Line-qualified events
  task automatic t_line;
    vdrb_host_model_inst.wr(ADDR_LINE, 8'h2a);
    cc(1'b0, 16'h1234);
    line(10'h00a, 3'b010);
    line(10'h10a, 3'b000);
    push(8'h77, 1'b1);
    line(10'h00a, 3'b110);
    rdchk("ttx", ADDR_TTX, 8'h77);
    vdrb_host_model_inst.wr(ADDR_LINE, 8'h0b);
    line(10'h00b, 3'b110);
    vdrb_host_model_inst.wr(ADDR_LINE, 8'h00);
    line(10'h000, 3'b000);
    rdchk("line", ADDR_LINE, 8'h00);
  endtask

  // Reset in mid-run restores configuration and empties the FIFO
  task automatic t_rst2;
    push(8'h11, 1'b1);
    @(posedge i_sys_clk);
    #1;
    i_reset = 1'b1;
    repeat (2) @(posedge i_sys_clk);
    #1;
    i_reset = 1'b0;
    rdchk("thr", ADDR_THR, 8'h05);
    rdchk("line", ADDR_LINE, 8'h38);
    rdchk("buf", ADDR_BUF, 8'h00);
  endtask

  // ****************************************************************
  // Verdict and run
  // ****************************************************************
  task automatic conclude;
    $display("checked %0d err_total %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Watchdog well above the expected run length
  initial
  begin
    #200000;
    err_total++;
    conclude();
  end

  // Main sequence
  initial
  begin
    repeat (2) @(posedge i_sys_clk);
    #1;
    i_reset = 1'b0;
    t_reset();
    t_ttx();
    t_fill();
    t_cc();
    t_line();
    t_rst2();
    conclude();
  end
endmodule
